// ---- cbsu_core.v ----
`include "cbsu_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cbsu_core #(
    parameter PC_W = 16 // Program counter width in bits.
) (
    input  wire            clk,          // Core clock, 20 MHz.
    input  wire            rst,          // Asynchronous reset, active high.
    input  wire            issue,        // One-cycle pulse: an operation is issued.
    input  wire [4:0]      op,           // Operation code.
    input  wire [7:0]      dst_val,      // Destination register value.
    input  wire [7:0]      src_val,      // Source register or bit-test register.
    input  wire [7:0]      imm,          // Immediate constant from instruction word.
    input  wire [7:0]      io_val,       // Addressed I/O register value.
    input  wire [2:0]      bit_sel,      // Bit or status flag index.
    input  wire [6:0]      offset,       // Signed branch displacement.
    input  wire            next_two_word, // Following instruction is two words.
    input  wire [PC_W-1:0] pc_in,        // Address of the issued instruction.
    input  wire [7:0]      status_register_in,      // Current status register.
    output reg             busy,         // High while extra cycles are spent.
    output reg             done,         // Pulse at the last cycle of an operation.
    output reg             pc_load,      // Pulse: load program counter.
    output reg  [PC_W-1:0] pc_out,       // New program counter value.
    output reg             flush,        // Pulse: discard fetched instruction.
    output reg             status_register_we,      // Pulse: write status register.
    output reg  [7:0]      status_register_out,     // New status register value.
    output reg  [1:0]      cycles        // Cycle cost of the last operation.
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    // Skip steps sized to the program counter so the additions stay in width.
    localparam [PC_W-1:0] STEP_SKIP1 = `CBSU_PC_STEP_SKIP1;
    localparam [PC_W-1:0] STEP_SKIP2 = `CBSU_PC_STEP_SKIP2;

    reg  [1:0]      state;
    reg  [1:0]      wait_cnt;
    reg  [1:0]      next_state;
    reg  [1:0]      next_wait;
    reg             is_cmp;
    reg             is_skip;
    reg             is_br;
    reg             cond;
    reg  [7:0]      sub_src;
    reg  [PC_W-1:0] next_pc;
    reg  [1:0]      next_cycles;
    reg             next_pc_load;
    reg             next_flush;
    wire [7:0]      sub_flags;
    wire [PC_W-1:0] pc_seq;
    wire [PC_W-1:0] offs_ext;
    wire            sel_s;
    wire            sel_r;
    wire            sel_p;

    assign sel_s    = status_register_in[bit_sel];
    assign sel_r    = src_val[bit_sel];
    assign sel_p    = io_val[bit_sel];
    assign pc_seq   = pc_in + {{(PC_W-1){1'b0}}, 1'b1};
    assign offs_ext = {{(PC_W-7){offset[6]}}, offset};

    cbsu_sub8 u_sub (
        .dst       (dst_val),
        .src       (sub_src),
        .cin       ((op == `CBSU_OP_CMP_CARRY) & status_register_in[`CBSU_SR_C]),
        .z_chain   (status_register_in[`CBSU_SR_Z]),
        .use_chain (op == `CBSU_OP_CMP_CARRY),
        .flags     (sub_flags)
    );

    always @* begin
        is_cmp  = 1'b0;
        is_skip = 1'b0;
        is_br   = 1'b0;
        cond    = 1'b0;
        sub_src = src_val;
        case (op)
            `CBSU_OP_CMP: begin
                is_cmp = 1'b1;
            end
            `CBSU_OP_CMP_CARRY: begin
                is_cmp = 1'b1;
            end
            `CBSU_OP_CMP_IMM: begin
                is_cmp  = 1'b1;
                sub_src = imm;
            end
            `CBSU_OP_SKIP_RB_CLR: begin
                is_skip = 1'b1;
                cond    = ~sel_r;
            end
            `CBSU_OP_SKIP_RB_SET: begin
                is_skip = 1'b1;
                cond    = sel_r;
            end
            `CBSU_OP_SKIP_IO_CLR: begin
                is_skip = 1'b1;
                cond    = ~sel_p;
            end
            `CBSU_OP_SKIP_IO_SET: begin
                is_skip = 1'b1;
                cond    = sel_p;
            end
            `CBSU_OP_BR_SBIT_SET: begin
                is_br = 1'b1;
                cond  = sel_s;
            end
            `CBSU_OP_BR_SBIT_CLR: begin
                is_br = 1'b1;
                cond  = ~sel_s;
            end
            `CBSU_OP_BR_EQ: begin
                is_br = 1'b1;
                cond  = status_register_in[`CBSU_SR_Z];
            end
            `CBSU_OP_BR_NE: begin
                is_br = 1'b1;
                cond  = ~status_register_in[`CBSU_SR_Z];
            end
            `CBSU_OP_BR_CS, `CBSU_OP_BR_LO: begin
                is_br = 1'b1;
                cond  = status_register_in[`CBSU_SR_C];
            end
            `CBSU_OP_BR_CC, `CBSU_OP_BR_SH: begin
                is_br = 1'b1;
                cond  = ~status_register_in[`CBSU_SR_C];
            end
            `CBSU_OP_BR_MI: begin
                is_br = 1'b1;
                cond  = status_register_in[`CBSU_SR_N];
            end
            `CBSU_OP_BR_PL: begin
                is_br = 1'b1;
                cond  = ~status_register_in[`CBSU_SR_N];
            end
            `CBSU_OP_BR_GE: begin
                is_br = 1'b1;
                cond  = ~(status_register_in[`CBSU_SR_N] ^ status_register_in[`CBSU_SR_V]);
            end
            `CBSU_OP_BR_LT: begin
                is_br = 1'b1;
                cond  = status_register_in[`CBSU_SR_N] ^ status_register_in[`CBSU_SR_V];
            end
            `CBSU_OP_BR_HS: begin
                is_br = 1'b1;
                cond  = status_register_in[`CBSU_SR_H];
            end
            `CBSU_OP_BR_HC: begin
                is_br = 1'b1;
                cond  = ~status_register_in[`CBSU_SR_H];
            end
            default: begin
                is_br = 1'b0;
            end
        endcase
    end

    always @* begin
        next_pc      = pc_seq;
        next_cycles  = `CBSU_CYC_FALL;
        next_pc_load = 1'b0;
        next_flush   = 1'b0;
        if (is_br && cond) begin
            next_pc      = pc_seq + offs_ext;
            next_cycles  = `CBSU_CYC_TAKEN;
            next_pc_load = 1'b1;
            next_flush   = 1'b1;
        end
        if (is_skip && cond) begin
            next_pc_load = 1'b1;
            next_flush   = 1'b1;
            if (next_two_word) begin
                next_pc     = pc_in + STEP_SKIP2;
                next_cycles = `CBSU_CYC_SKIP2;
            end else begin
                next_pc     = pc_in + STEP_SKIP1;
                next_cycles = `CBSU_CYC_TAKEN;
            end
        end
    end

    always @* begin
        next_state = state;
        next_wait  = wait_cnt;
        case (state)
            ST_IDLE: begin
                if (issue && next_cycles != `CBSU_CYC_FALL) begin
                    next_state = ST_WAIT;
                    next_wait  = next_cycles - 2'h1;
                end
            end
            ST_WAIT: begin
                next_wait = wait_cnt - 2'h1;
                if (wait_cnt == 2'h1) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            wait_cnt <= 2'h0;
            busy     <= 1'b0;
            done     <= 1'b0;
            pc_load  <= 1'b0;
            pc_out   <= `CBSU_PC_RESET;
            flush    <= 1'b0;
            status_register_we  <= 1'b0;
            status_register_out <= `CBSU_SR_RESET;
            cycles   <= 2'h0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait;
            busy     <= (next_state == ST_WAIT);
            done     <= (state == ST_IDLE) ? (issue && next_cycles == `CBSU_CYC_FALL)
                                           : (wait_cnt == 2'h1);
            pc_load  <= 1'b0;
            flush    <= 1'b0;
            status_register_we  <= 1'b0;
            if (issue && state == ST_IDLE) begin
                pc_load <= next_pc_load;
                pc_out  <= next_pc;
                flush   <= next_flush;
                cycles  <= next_cycles;
                // Compares touch only C Z N V S H; I and T are kept.
                if (is_cmp) begin
                    status_register_we  <= 1'b1;
                    status_register_out <= {status_register_in[7:6], sub_flags[5:0]};
                end else begin
                    status_register_out <= status_register_in;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- cbsu_map.vh ----
`ifndef CBSU_MAP_VH
`define CBSU_MAP_VH

// Operation codes presented by the core decoder.
`define CBSU_OP_W            5
`define CBSU_OP_NONE         5'h00
`define CBSU_OP_CMP          5'h01
`define CBSU_OP_CMP_CARRY    5'h02
`define CBSU_OP_CMP_IMM      5'h03
`define CBSU_OP_SKIP_RB_CLR  5'h04
`define CBSU_OP_SKIP_RB_SET  5'h05
`define CBSU_OP_SKIP_IO_CLR  5'h06
`define CBSU_OP_SKIP_IO_SET  5'h07
`define CBSU_OP_BR_SBIT_SET  5'h08
`define CBSU_OP_BR_SBIT_CLR  5'h09
`define CBSU_OP_BR_EQ        5'h0A
`define CBSU_OP_BR_NE        5'h0B
`define CBSU_OP_BR_CS        5'h0C
`define CBSU_OP_BR_CC        5'h0D
`define CBSU_OP_BR_SH        5'h0E
`define CBSU_OP_BR_LO        5'h0F
`define CBSU_OP_BR_MI        5'h10
`define CBSU_OP_BR_PL        5'h11
`define CBSU_OP_BR_GE        5'h12
`define CBSU_OP_BR_LT        5'h13
`define CBSU_OP_BR_HS        5'h14
`define CBSU_OP_BR_HC        5'h15

// Status register bit positions.
`define CBSU_SR_C            0
`define CBSU_SR_Z            1
`define CBSU_SR_N            2
`define CBSU_SR_V            3
`define CBSU_SR_S            4
`define CBSU_SR_H            5
`define CBSU_SR_T            6
`define CBSU_SR_I            7
`define CBSU_SR_RESET        8'h00

// Program counter steps and cycle costs.
`define CBSU_PC_STEP_SKIP1   2
`define CBSU_PC_STEP_SKIP2   3
`define CBSU_CYC_FALL        2'h1
`define CBSU_CYC_TAKEN       2'h2
`define CBSU_CYC_SKIP2       2'h3
`define CBSU_PC_RESET        16'h0000

`endif

// ---- cbsu_sub8.v ----
`timescale 1ns/1ps
`default_nettype none

module cbsu_sub8 (
    input  wire [7:0] dst,       // Minuend.
    input  wire [7:0] src,       // Subtrahend.
    input  wire       cin,       // Borrow in.
    input  wire       z_chain,   // Previous zero flag, for chained compare.
    input  wire       use_chain, // Keep zero only if previous was zero.
    output wire [7:0] flags      // New status bits C,Z,N,V,S,H in place.
);
    wire [8:0] diff;
    wire       c_f;
    wire       z_f;
    wire       n_f;
    wire       v_f;
    wire       h_f;

    assign diff = {1'b0, dst} - {1'b0, src} - {8'h00, cin};
    assign c_f  = (~dst[7] & src[7]) | (src[7] & diff[7]) | (diff[7] & ~dst[7]);
    assign h_f  = (~dst[3] & src[3]) | (src[3] & diff[3]) | (diff[3] & ~dst[3]);
    assign v_f  = (dst[7] & ~src[7] & ~diff[7]) | (~dst[7] & src[7] & diff[7]);
    assign n_f  = diff[7];
    // With carry, a zero result only keeps Z so multi-byte compares chain.
    assign z_f  = (diff[7:0] == 8'h00) & (~use_chain | z_chain);
    assign flags = {2'b00, h_f, n_f ^ v_f, v_f, n_f, z_f, c_f};
endmodule

`default_nettype wire

// ---- cbsu_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cbsu_map.vh"
module cbsu_chk #(
    parameter PC_W = 16
) (
    input wire logic            clk,           // Clock.
    input wire logic            rst,           // Reset.
    input wire logic            issue,         // Strobe.
    input wire logic [4:0]      op,            // Opcode.
    input wire logic [7:0]      dst_val,       // Minuend.
    input wire logic [7:0]      src_val,       // Source.
    input wire logic [7:0]      imm,           // Constant.
    input wire logic [7:0]      io_val,        // I/O value.
    input wire logic [2:0]      bit_sel,       // Index.
    input wire logic [6:0]      offset,        // Offset.
    input wire logic            next_two_word, // Long word.
    input wire logic [PC_W-1:0] pc_in,         // Address.
    input wire logic [7:0]      status_register_in,       // Status.
    input wire logic            busy,          // Busy.
    input wire logic            done,          // Done.
    input wire logic            pc_load,       // Jump.
    input wire logic [PC_W-1:0] pc_out,        // Target.
    input wire logic            flush,         // Flush.
    input wire logic            status_register_we,       // Write.
    input wire logic [7:0]      status_register_out,      // New status.
    input wire logic [1:0]      cycles         // Cost.
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // An issue counts only when the unit is idle; busy issues are dropped.
    wire            go  = issue && !busy;
    wire            nxv = status_register_in[2] ^ status_register_in[3];
    wire            zf  = status_register_in[1];
    wire [PC_W-1:0] ext = {{(PC_W-7){offset[6]}}, offset};
    sequence s_skip_long;
        go && op == 5'h04 && !src_val[bit_sel] && next_two_word;
    endsequence
    sequence s_three;
        pc_load && flush && busy ##1 busy && !done ##1 done && !busy;
    endsequence
    a_cmp_one_cycle: assert property (go && op inside {[1:3]} |=>
        status_register_we && done && !pc_load && cycles == 2'h1) else $error("compare timing wrong");
    a_cmp_zero_flag: assert property (go && op == 5'h01 |=>
        status_register_out[1] == ($past(dst_val) == $past(src_val))) else $error("compare zero wrong");
    a_cmpi_borrow: assert property (go && op == 5'h03 |=>
        status_register_out[0] == ($past(dst_val) < $past(imm))) else $error("immediate borrow wrong");
    a_skip_long_cost: assert property (s_skip_long |=>
        pc_out == $past(pc_in) + 3 ##0 s_three) else $error("long skip wrong");
    a_io_skip_short: assert property (go && op == 5'h06 && !io_val[bit_sel] &&
        !next_two_word |=> pc_load && pc_out == $past(pc_in) + 2 ##1 done)
        else $error("I/O skip wrong");
    a_skip_no_flags: assert property (go && op inside {[4:7]} |=> !status_register_we)
        else $error("skip wrote status");
    a_branch_taken: assert property (go && op == 5'h08 && status_register_in[bit_sel] |=>
        pc_load && flush && pc_out == PC_W'($past(pc_in) + $past(ext) + 1) ##1 done && !busy)
        else $error("taken branch wrong");
    a_branch_falls: assert property (go && op == 5'h09 && status_register_in[bit_sel] |=>
        done && !pc_load && !busy && cycles == 2'h1) else $error("untaken branch wrong");
    a_branch_eq_z: assert property (go && op == 5'h0A |=> pc_load == $past(zf))
        else $error("equal branch wrong");
    a_branch_lt_nv: assert property (go && op == 5'h13 |=> pc_load == $past(nxv))
        else $error("signed less branch wrong");
endmodule
bind cbsu_core cbsu_chk #(.PC_W(PC_W)) u_chk (
    .clk(clk), .rst(rst), .issue(issue), .op(op), .dst_val(dst_val), .src_val(src_val),
    .imm(imm), .io_val(io_val), .bit_sel(bit_sel), .offset(offset),
    .next_two_word(next_two_word), .pc_in(pc_in), .status_register_in(status_register_in), .busy(busy),
    .done(done), .pc_load(pc_load), .pc_out(pc_out), .flush(flush), .status_register_we(status_register_we),
    .status_register_out(status_register_out), .cycles(cycles)
);
`default_nettype wire

// ---- compare_branch_skip_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module compare_branch_skip_unit_test;
    logic        clk, rst, issue, tw;
    logic [4:0]  op;
    logic [7:0]  d, s, k, io, sr;
    logic [2:0]  b;
    logic [6:0]  f;
    logic [15:0] pc;
    wire         busy, done, pl, fl, we;
    wire  [15:0] po;
    wire  [7:0]  so;
    wire  [1:0]  cy;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    cbsu_core uut (
        .clk(clk), .rst(rst), .issue(issue), .op(op), .dst_val(d), .src_val(s), .imm(k),
        .io_val(io), .bit_sel(b), .offset(f), .next_two_word(tw), .pc_in(pc), .status_register_in(sr),
        .busy(busy), .done(done), .pc_load(pl), .pc_out(po), .flush(fl), .status_register_we(we),
        .status_register_out(so), .cycles(cy)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Called at a falling edge; returns one cycle later with the first answer settled.
    task automatic run(input logic [4:0] o, input logic [7:0] dv, sv, kv, iv, st,
                       input logic [2:0] bv, input logic [6:0] fv, input logic t);
        {op, d, s, k, io, sr, b, f, tw} = {o, dv, sv, kv, iv, st, bv, fv, t};
        issue = 1'b1;
        @(negedge clk);
        issue = 1'b0;
    endtask
    task automatic wait_done(output int n);
        n = 1;
        while (done !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
    endtask
    function automatic logic [7:0] flags(input logic [7:0] x, y, st, input logic ci, ch);
        logic [7:0] r;
        logic       hv, cv, vv;
        r = x - y - ci;
        hv = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
        cv = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
        vv = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
        return {st[7:6], hv, r[7] ^ vv, vv, r[7], (r == 8'h00) & (st[1] | ~ch), cv};
    endfunction
    function automatic logic take(input int o, input logic [7:0] q);
        case (o)
            8, 20: return q[5];
            9, 21: return ~q[5];
            10: return q[1];
            11: return ~q[1];
            12, 15: return q[0];
            13, 14: return ~q[0];
            16: return q[2];
            17: return ~q[2];
            18: return ~(q[2] ^ q[3]);
            default: return q[2] ^ q[3];
        endcase
    endfunction
    // Operands d, s, k, status; the decoy operand catches a wrong subtrahend.
    task automatic t_compare;
        logic [31:0] tb [3] = '{32'h1020AAC0, 32'h201FAA03, 32'h80550100};
        logic [7:0]  y;
        for (int i = 0; i < 3; i++) begin
            y = i == 2 ? tb[i][15:8] : tb[i][23:16];
            run(i + 1, tb[i][31:24], tb[i][23:16], tb[i][15:8], 8'h00, tb[i][7:0], 3'h0,
                7'h00, 1'b0);
            chk({we, pl, done, cy}, 5'h15);
            chk(so, flags(tb[i][31:24], y, tb[i][7:0], i == 1 & tb[i][0], i == 1));
        end
    endtask
    // The unused source carries the opposite bit, so a wrong source shows up.
    task automatic t_skip;
        logic [7:0] vb;
        int         n;
        for (int o = 4; o < 8; o++)
            for (int m = 0; m < 3; m++) begin
                vb = ((m != 0) == o[0]) ? 8'h20 : 8'hDF;
                run(o, 8'h00, o < 6 ? vb : ~vb, 8'h00, o < 6 ? ~vb : vb, 8'hFF, 3'h5, 7'h00, m == 2);
                chk({pl, fl, we}, {{2{m != 0}}, 1'b0});
                if (m != 0)
                    chk(po, pc + m + 1);
                wait_done(n);
                chk(n, m + 1);
                chk(cy, m + 1);
            end
    endtask
    // Three status patterns give both outcomes of every condition, N xor V included.
    task automatic t_branch;
        logic [7:0] st;
        logic [6:0] fv;
        logic       tk;
        int         n;
        for (int o = 8; o < 22; o++)
            for (int p = 0; p < 3; p++) begin
                st = p == 0 ? 8'h25 : p == 1 ? 8'hDA : 8'h0C;
                fv = p == 0 ? 7'h7E : p == 1 ? 7'h05 : 7'h40;
                tk = take(o, st);
                run(o, 8'h00, 8'h00, 8'h00, 8'h00, st, 3'h5, fv, 1'b0);
                chk({pl, fl, we}, {tk, tk, 1'b0});
                if (tk)
                    chk(po, pc + {{9{fv[6]}}, fv} + 16'h0001);
                wait_done(n);
                chk(n, tk + 1);
            end
    endtask
    // A compare offered while busy must vanish; reset then cuts a long skip short.
    task automatic t_refuse_reset;
        run(5'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 3'h5, 7'h02, 1'b0);
        run(5'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
        chk({done, we}, 2'h2);
        run(5'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 3'h5, 7'h00, 1'b1);
        rst = 1'b1;
        @(negedge clk);
        chk({busy, done, pl, we}, 4'h0);
        rst = 1'b0;
        run(5'h01, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
        chk({we, pl, done, cy}, 5'h15);
    endtask
    initial begin
        rst = 1'b1;
        issue = 1'b0;
        {op, d, s, k, io, sr, b, f, tw} = '0;
        pc = 16'h0100;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_compare();
        t_skip();
        t_branch();
        t_refuse_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
